// [include/cpx_cir_if.sv]
// interface register link between main processor end and coprocessor end
`timescale 1ns/1ps
interface cpx_cir_if;
  logic [2:0]  cir_sel;
  logic        cir_rd;
  logic        cir_wr;
  logic [31:0] cir_wdata;
  logic [31:0] cir_rdata;
  logic        cp_complete;

  modport main (output cir_sel, output cir_rd, output cir_wr, output cir_wdata,
                input cir_rdata, input cp_complete);
  modport copro (input cir_sel, input cir_rd, input cir_wr, input cir_wdata,
                 output cir_rdata, output cp_complete);
endinterface : cpx_cir_if

// [include/cpx_pkg.sv]
// shared constants and types for the coprocessor multi-operand and status transfer link
package cpx_pkg;

  // ----------------------------------------------------------------------
  // primitive word fields
  // ----------------------------------------------------------------------
  localparam int          CA_BIT      = 15;
  localparam int          PC_BIT      = 14;
  localparam int          DR_BIT      = 13;
  localparam int          SP_BIT      = 0;
  localparam int          PAT_HI      = 12;
  localparam int          PAT_LO      = 8;
  localparam logic [4:0]  MULTI_PAT   = 5'h01;
  localparam logic [4:0]  STAT_PAT    = 5'h02;

  // ----------------------------------------------------------------------
  // status word fields and fixed values
  // ----------------------------------------------------------------------
  localparam int          TRACE_HI    = 15;
  localparam int          TRACE_LO    = 14;
  localparam logic [1:0]  TRACE_FLOW  = 2'h1;
  localparam int          SUPER_BIT   = 13;
  localparam logic [31:0] ABORT_MASK  = 32'h0000_0002;
  localparam logic [2:0]  SIZE_LONG   = 3'h4;
  localparam logic [2:0]  SIZE_WORD   = 3'h2;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // interface register select codes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CIR_RESP  = 3'h0,
    CIR_CTRL  = 3'h1,
    CIR_SEL   = 3'h2,
    CIR_OPND  = 3'h3,
    CIR_IADDR = 3'h4
  } cpx_cir_e;

  // ----------------------------------------------------------------------
  // main processor end sequencer states, gray along the usual path
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_RESP  = 4'h1,
    ST_DEC   = 4'h3,
    ST_EA    = 4'h2,
    ST_MASK  = 4'h6,
    ST_OPST  = 4'h7,
    ST_PART  = 4'h5,
    ST_PCAP  = 4'h4,
    ST_MWAIT = 4'hC,
    ST_FIN   = 4'hD,
    ST_ABORT = 4'hF,
    ST_SRA   = 4'hE,
    ST_SRB   = 4'hA,
    ST_SRC   = 4'hB,
    ST_FILL  = 4'h9
  } cpx_state_e;

endpackage : cpx_pkg

// [logic/cpx_copro_end.sv]
// coprocessor end: answers interface register accesses from the main processor
`timescale 1ns/1ps
module cpx_copro_end (
  input  wire logic        core_clk,
  input  wire logic        rst,
  cpx_cir_if.copro         cir,
  input  wire logic [15:0] resp_word,
  input  wire logic [15:0] sel_mask,
  input  wire logic [31:0] op_in,
  input  wire logic [31:0] ia_in,
  input  wire logic        complete,
  output logic             resp_take,
  output logic             op_take,
  output logic [31:0]      op_out,
  output logic             op_put,
  output logic [31:0]      ia_out,
  output logic             ia_put,
  output logic [31:0]      ctrl_out,
  output logic             ctrl_put,
  output logic             odd_len
);

  logic [31:0] rdata_q;
  logic        cmpl_q;
  logic        resp_take_q;
  logic        op_take_q;
  logic [31:0] op_out_q;
  logic        op_put_q;
  logic [31:0] ia_out_q;
  logic        ia_put_q;
  logic [31:0] ctrl_out_q;
  logic        ctrl_put_q;
  logic        odd_len_q;

  // ----------------------------------------------------------------------
  // access decode and read selection
  // ----------------------------------------------------------------------
  wire rd_resp  = cir.cir_rd && (cir.cir_sel == cpx_pkg::CIR_RESP);
  wire rd_sel   = cir.cir_rd && (cir.cir_sel == cpx_pkg::CIR_SEL);
  wire rd_opnd  = cir.cir_rd && (cir.cir_sel == cpx_pkg::CIR_OPND);
  wire rd_ia    = cir.cir_rd && (cir.cir_sel == cpx_pkg::CIR_IADDR);
  wire wr_opnd  = cir.cir_wr && (cir.cir_sel == cpx_pkg::CIR_OPND);
  wire wr_ia    = cir.cir_wr && (cir.cir_sel == cpx_pkg::CIR_IADDR);
  wire wr_ctrl  = cir.cir_wr && (cir.cir_sel == cpx_pkg::CIR_CTRL);
  // RQ1: multi primitive pattern in bits 12..8
  wire is_multi = resp_word[cpx_pkg::PAT_HI:cpx_pkg::PAT_LO] == cpx_pkg::MULTI_PAT;
  // RQ8: mask handed out as sixteen bits, upper half zero
  wire [31:0] rd_mux = rd_resp ? {16'h0000, resp_word} :
                       rd_sel  ? {16'h0000, sel_mask}  :
                       rd_opnd ? op_in                  :
                       rd_ia   ? ia_in                  : cpx_pkg::RST_WORD;

  // ----------------------------------------------------------------------
  // registered answers, one cycle after the strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q     <= cpx_pkg::RST_WORD;
      cmpl_q      <= 1'b0;
      resp_take_q <= 1'b0;
      op_take_q   <= 1'b0;
      op_out_q    <= cpx_pkg::RST_WORD;
      op_put_q    <= 1'b0;
      ia_out_q    <= cpx_pkg::RST_WORD;
      ia_put_q    <= 1'b0;
      ctrl_out_q  <= cpx_pkg::RST_WORD;
      ctrl_put_q  <= 1'b0;
      odd_len_q   <= 1'b0;
    end else begin
      rdata_q     <= rd_mux;
      cmpl_q      <= complete;
      resp_take_q <= rd_resp;
      op_take_q   <= rd_opnd;
      op_put_q    <= wr_opnd;
      // RQ12: scan pointer moves only through the address register
      ia_put_q    <= wr_ia;
      ctrl_put_q  <= wr_ctrl;
      // RQ4: flag an odd length handed out by the user side
      odd_len_q   <= rd_resp && is_multi && resp_word[0];
      if (wr_opnd) begin
        op_out_q <= cir.cir_wdata;
      end
      if (wr_ia) begin
        ia_out_q <= cir.cir_wdata;
      end
      if (wr_ctrl) begin
        ctrl_out_q <= cir.cir_wdata;
      end
    end
  end

  // outputs straight from flops
  assign cir.cir_rdata   = rdata_q;
  assign cir.cp_complete = cmpl_q;
  assign resp_take       = resp_take_q;
  assign op_take         = op_take_q;
  assign op_out          = op_out_q;
  assign op_put          = op_put_q;
  assign ia_out          = ia_out_q;
  assign ia_put          = ia_put_q;
  assign ctrl_out        = ctrl_out_q;
  assign ctrl_put        = ctrl_put_q;
  assign odd_len         = odd_len_q;

endmodule : cpx_copro_end

// [logic/cpx_main_end.sv]
// main processor end: runs multi-operand and status transfer primitives
// Summary of operation
// RQ1: primitive carries flags, pattern 00001, length
// RQ2: move zero to sixteen operands
// RQ3: conditional category gives protocol violation
// RQ4: odd operand length gives protocol violation
// RQ5: compute address, scan pointer plus two each
// RQ6: direction selects the accepted addressing modes
// RQ7: bad mode writes abort, then F-line exception
// RQ8: operand count is ones in mask
// RQ9: direction sets operand flow, longs preferred
// RQ10: ascending addresses, postincrement adds total bytes
// RQ11: predecrement before each operand, bytes ascending
// RQ12: select flag adds scan pointer to status
// RQ13: status word written or loaded via operand
// RQ14: scan pointer first out, status first in
// RQ15: inbound status flushes prefetch, refetch at pointer
// RQ16: flow trace mode gives trace at completion
// RQ17: loaded trace bits act from next instruction
`timescale 1ns/1ps
module cpx_main_end (
  input  wire logic        core_clk,
  input  wire logic        rst,
  cpx_cir_if.main          cir,
  input  wire logic        instr_start,
  input  wire logic        prim_go,
  input  wire logic        cond_cat,
  input  wire logic [15:0] status_in,
  input  wire logic [31:0] scan_in,
  input  wire logic        ea_ctrl,
  input  wire logic        ea_alter,
  input  wire logic        ea_postinc,
  input  wire logic        ea_predec,
  input  wire logic [2:0]  ea_ext_words,
  input  wire logic [31:0] ea_addr,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  output logic             busy,
  output logic             done,
  output logic             come_again,
  output logic             proto_viol,
  output logic             fline_exc,
  output logic             unhandled,
  output logic             trace_exc,
  output logic [15:0]      status_out,
  output logic             status_load,
  output logic [31:0]      scan_out,
  output logic [31:0]      an_out,
  output logic             an_load,
  output logic             flush,
  output logic [31:0]      fetch_addr,
  output logic             fetch_super,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [2:0]       mem_size,
  output logic [31:0]      mem_wdata
);

  // counts ones anywhere in the mask
  function automatic logic [4:0] ones16(input logic [15:0] m);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      n = n + {4'h0, m[i]};
    end
    return n;
  endfunction : ones16

  cpx_pkg::cpx_state_e state_q;
  logic [15:0] prim_q;
  logic        cond_q;
  logic        ctrl_q, alter_q, post_q, pre_q;
  logic [2:0]  ext_q;
  logic [4:0]  cnt_q;
  logic [31:0] an_q, base_q, data_q, scan_q, fetch_q;
  logic [15:0] stat_q;
  logic [7:0]  off_q;
  logic        arm_q, pend_q, super_q;
  logic        done_q, ca_q, pv_q, fl_q, un_q, tr_q, sl_q, al_q, fsh_q;
  logic [2:0]  sel_q;
  logic        rd_q, wr_q;
  logic [31:0] wd_q;
  logic        mreq_q, mwe_q;
  logic [31:0] maddr_q;
  logic [2:0]  msize_q;

  // ----------------------------------------------------------------------
  // primitive decode and transfer geometry
  // ----------------------------------------------------------------------
  // RQ1: flags in 15..13, pattern 12..8, length 7..0
  wire        dr        = prim_q[cpx_pkg::DR_BIT];
  wire        sp        = prim_q[cpx_pkg::SP_BIT];
  wire [7:0]  len       = prim_q[7:0];
  wire        is_multi  = prim_q[cpx_pkg::PAT_HI:cpx_pkg::PAT_LO] == cpx_pkg::MULTI_PAT;
  wire        is_stat   = prim_q[cpx_pkg::PAT_HI:cpx_pkg::PAT_LO] == cpx_pkg::STAT_PAT;
  // RQ6: inbound needs control or postinc, outbound control alterable or predec
  wire        ea_ok     = dr ? ((ctrl_q && alter_q) || pre_q) : (ctrl_q || post_q);
  // RQ9: long parts while four bytes remain, a word for the even tail
  wire [7:0]  remain    = len - off_q;
  wire [2:0]  psz       = (remain >= 8'h04) ? cpx_pkg::SIZE_LONG : cpx_pkg::SIZE_WORD;
  wire [7:0]  off_nx    = off_q + {5'h00, psz};
  wire        last_part = off_nx == len;
  wire [31:0] part_addr = base_q + {24'h000000, off_q};
  wire [31:0] op_end    = base_q + {24'h000000, len};
  wire [31:0] pre_base  = an_q - {24'h000000, len};
  wire [4:0]  mask_cnt  = ones16(cir.cir_rdata[15:0]);
  wire [31:0] scan_adv  = scan_q + {28'h0000000, ext_q, 1'b0};

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= cpx_pkg::ST_IDLE;
      prim_q  <= 16'h0000;
      cond_q  <= 1'b0;
      ctrl_q  <= 1'b0;
      alter_q <= 1'b0;
      post_q  <= 1'b0;
      pre_q   <= 1'b0;
      ext_q   <= 3'h0;
      cnt_q   <= 5'h00;
      an_q    <= cpx_pkg::RST_WORD;
      base_q  <= cpx_pkg::RST_WORD;
      data_q  <= cpx_pkg::RST_WORD;
      scan_q  <= cpx_pkg::RST_WORD;
      fetch_q <= cpx_pkg::RST_WORD;
      stat_q  <= 16'h0000;
      off_q   <= 8'h00;
      arm_q   <= 1'b0;
      pend_q  <= 1'b0;
      super_q <= 1'b0;
      done_q  <= 1'b0;
      ca_q    <= 1'b0;
      pv_q    <= 1'b0;
      fl_q    <= 1'b0;
      un_q    <= 1'b0;
      tr_q    <= 1'b0;
      sl_q    <= 1'b0;
      al_q    <= 1'b0;
      fsh_q   <= 1'b0;
      sel_q   <= cpx_pkg::CIR_RESP;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      wd_q    <= cpx_pkg::RST_WORD;
      mreq_q  <= 1'b0;
      mwe_q   <= 1'b0;
      maddr_q <= cpx_pkg::RST_WORD;
      msize_q <= cpx_pkg::SIZE_LONG;
    end else begin
      // one-cycle strobes fall back unless set below
      done_q <= 1'b0;
      pv_q   <= 1'b0;
      fl_q   <= 1'b0;
      un_q   <= 1'b0;
      sl_q   <= 1'b0;
      al_q   <= 1'b0;
      fsh_q  <= 1'b0;
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
      mreq_q <= 1'b0;
      // RQ16: trace fires when coprocessor reports completion
      tr_q   <= pend_q && cir.cp_complete;
      if (pend_q && cir.cp_complete) begin
        pend_q <= 1'b0;
      end
      // RQ17: trace arming sampled at instruction start only
      if (instr_start) begin
        arm_q  <= status_in[cpx_pkg::TRACE_HI:cpx_pkg::TRACE_LO] == cpx_pkg::TRACE_FLOW;
        pend_q <= 1'b0;
      end
      case (state_q)
        cpx_pkg::ST_IDLE: begin
          if (prim_go) begin
            scan_q  <= scan_in;
            stat_q  <= status_in;
            an_q    <= ea_addr;
            cond_q  <= cond_cat;
            ctrl_q  <= ea_ctrl;
            alter_q <= ea_alter;
            post_q  <= ea_postinc;
            pre_q   <= ea_predec;
            ext_q   <= ea_ext_words;
            sel_q   <= cpx_pkg::CIR_RESP;
            rd_q    <= 1'b1;
            state_q <= cpx_pkg::ST_RESP;
          end
        end
        cpx_pkg::ST_RESP: begin
          prim_q  <= cir.cir_rdata[15:0];
          state_q <= cpx_pkg::ST_DEC;
        end
        cpx_pkg::ST_DEC: begin
          ca_q <= prim_q[cpx_pkg::CA_BIT];
          if (!(is_multi || is_stat)) begin
            un_q    <= 1'b1;
            state_q <= cpx_pkg::ST_IDLE;
          // RQ3: general category only
          end else if (cond_q) begin
            pv_q    <= 1'b1;
            state_q <= cpx_pkg::ST_IDLE;
          // RQ4: odd operand length refused
          end else if (is_multi && len[0]) begin
            pv_q    <= 1'b1;
            state_q <= cpx_pkg::ST_IDLE;
          end else begin
            state_q <= is_stat ? cpx_pkg::ST_SRA : cpx_pkg::ST_EA;
          end
        end
        cpx_pkg::ST_EA: begin
          if (!ea_ok) begin
            // RQ7: abort mask before the F-line exception
            sel_q   <= cpx_pkg::CIR_CTRL;
            wd_q    <= cpx_pkg::ABORT_MASK;
            wr_q    <= 1'b1;
            state_q <= cpx_pkg::ST_ABORT;
          end else begin
            // RQ5: two bytes per extension word, then read mask
            scan_q  <= scan_adv;
            sel_q   <= cpx_pkg::CIR_SEL;
            rd_q    <= 1'b1;
            state_q <= cpx_pkg::ST_MASK;
          end
        end
        cpx_pkg::ST_ABORT: begin
          fl_q    <= 1'b1;
          state_q <= cpx_pkg::ST_IDLE;
        end
        cpx_pkg::ST_MASK: begin
          // RQ8: count of ones, positions ignored
          cnt_q   <= mask_cnt;
          off_q   <= 8'h00;
          // RQ2: zero operands or zero length finish at once
          state_q <= (mask_cnt == 5'h00 || len == 8'h00) ? cpx_pkg::ST_FIN : cpx_pkg::ST_OPST;
        end
        cpx_pkg::ST_OPST: begin
          // RQ11: register drops one operand before each operand
          if (pre_q) begin
            base_q <= pre_base;
            an_q   <= pre_base;
          end else begin
            base_q <= an_q;
          end
          state_q <= cpx_pkg::ST_PART;
        end
        cpx_pkg::ST_PART: begin
          // RQ9: outbound reads operand register first, inbound reads memory
          if (dr) begin
            sel_q   <= cpx_pkg::CIR_OPND;
            rd_q    <= 1'b1;
            state_q <= cpx_pkg::ST_PCAP;
          end else begin
            mreq_q  <= 1'b1;
            mwe_q   <= 1'b0;
            maddr_q <= part_addr;
            msize_q <= psz;
            state_q <= cpx_pkg::ST_MWAIT;
          end
        end
        cpx_pkg::ST_PCAP: begin
          data_q  <= cir.cir_rdata;
          mreq_q  <= 1'b1;
          mwe_q   <= 1'b1;
          maddr_q <= part_addr;
          msize_q <= psz;
          state_q <= cpx_pkg::ST_MWAIT;
        end
        cpx_pkg::ST_MWAIT: begin
          if (mem_ack) begin
            if (!dr) begin
              data_q <= mem_rdata;
              sel_q  <= cpx_pkg::CIR_OPND;
              wd_q   <= mem_rdata;
              wr_q   <= 1'b1;
            end
            if (last_part) begin
              // RQ10: ascending modes step past the whole operand
              if (!pre_q) begin
                an_q <= op_end;
              end
              off_q   <= 8'h00;
              cnt_q   <= cnt_q - 5'h01;
              state_q <= (cnt_q == 5'h01) ? cpx_pkg::ST_FIN : cpx_pkg::ST_OPST;
            end else begin
              off_q   <= off_nx;
              state_q <= cpx_pkg::ST_PART;
            end
          end
        end
        cpx_pkg::ST_SRA: begin
          // RQ12: select flag adds the scan pointer leg
          if (dr) begin
            sel_q   <= cpx_pkg::CIR_OPND;
            rd_q    <= 1'b1;
            state_q <= cpx_pkg::ST_SRB;
          end else if (sp) begin
            // RQ14: scan pointer out ahead of status
            sel_q   <= cpx_pkg::CIR_IADDR;
            wd_q    <= scan_q;
            wr_q    <= 1'b1;
            state_q <= cpx_pkg::ST_SRB;
          end else begin
            // RQ13: status word alone to operand register
            sel_q   <= cpx_pkg::CIR_OPND;
            wd_q    <= {16'h0000, stat_q};
            wr_q    <= 1'b1;
            state_q <= cpx_pkg::ST_FIN;
          end
        end
        cpx_pkg::ST_SRB: begin
          if (dr) begin
            // RQ13: status loaded from operand register
            stat_q <= cir.cir_rdata[15:0];
            sl_q   <= 1'b1;
            if (sp) begin
              // RQ14: scan pointer read after status
              sel_q   <= cpx_pkg::CIR_IADDR;
              rd_q    <= 1'b1;
              state_q <= cpx_pkg::ST_SRC;
            end else begin
              state_q <= cpx_pkg::ST_FILL;
            end
          end else begin
            sel_q   <= cpx_pkg::CIR_OPND;
            wd_q    <= {16'h0000, stat_q};
            wr_q    <= 1'b1;
            state_q <= cpx_pkg::ST_FIN;
          end
        end
        cpx_pkg::ST_SRC: begin
          scan_q  <= cir.cir_rdata;
          state_q <= cpx_pkg::ST_FILL;
        end
        cpx_pkg::ST_FILL: begin
          // RQ15: drop prefetch, refill at pointer in status space
          fsh_q   <= 1'b1;
          fetch_q <= scan_q;
          super_q <= stat_q[cpx_pkg::SUPER_BIT];
          // RQ16: arm only if flow tracing held at start
          if (arm_q) begin
            pend_q <= 1'b1;
          end
          state_q <= cpx_pkg::ST_FIN;
        end
        cpx_pkg::ST_FIN: begin
          done_q  <= 1'b1;
          al_q    <= is_multi && (post_q || pre_q);
          state_q <= cpx_pkg::ST_IDLE;
        end
        default: begin
          state_q <= cpx_pkg::ST_IDLE;
        end
      endcase
      // rdata stands a cycle after the strobe
      if (rd_q) begin
        state_q <= state_q;
        rd_q    <= 1'b0;
        mreq_q  <= 1'b0;
        sl_q    <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs straight from flops, busy decoded from the state
  // ----------------------------------------------------------------------
  assign cir.cir_sel   = sel_q;
  assign cir.cir_rd    = rd_q;
  assign cir.cir_wr    = wr_q;
  assign cir.cir_wdata = wd_q;
  assign busy          = state_q != cpx_pkg::ST_IDLE;
  assign done          = done_q;
  assign come_again    = ca_q;
  assign proto_viol    = pv_q;
  assign fline_exc     = fl_q;
  assign unhandled     = un_q;
  assign trace_exc     = tr_q;
  assign status_out    = stat_q;
  assign status_load   = sl_q;
  assign scan_out      = scan_q;
  assign an_out        = an_q;
  assign an_load       = al_q;
  assign flush         = fsh_q;
  assign fetch_addr    = fetch_q;
  assign fetch_super   = super_q;
  assign mem_req       = mreq_q;
  assign mem_we        = mwe_q;
  assign mem_addr      = maddr_q;
  assign mem_size      = msize_q;
  assign mem_wdata     = data_q;

endmodule : cpx_main_end

// [sim/cpx_link_sva.sv]
// link checks on the interface register wires between the two ends
`timescale 1ns/1ps
module cpx_link_sva (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [2:0]  cir_sel,
  input wire logic        cir_rd,
  input wire logic        cir_wr,
  input wire logic [31:0] cir_wdata,
  input wire logic [31:0] cir_rdata,
  input wire logic        cp_complete
);
  // ----------------------------------------
  // strobe, select and data checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  AST_ONE_STROBE: assert property (!(cir_rd && cir_wr))
    else $error("strobe clash");
  AST_RDATA_IDLE: assert property (!cir_rd |=> cir_rdata == 32'h0)
    else $error("data without read");
  AST_ABORT_VAL: assert property (cir_wr && cir_sel == cpx_pkg::CIR_CTRL |->
    cir_wdata == cpx_pkg::ABORT_MASK) else $error("bad abort value");
  AST_ABORT_LAST: assert property (cir_wr && cir_sel == cpx_pkg::CIR_CTRL |=>
    (!cir_rd && !cir_wr) [*2]) else $error("traffic after abort");
  AST_WR_SEL: assert property (cir_wr |-> cir_sel inside {cpx_pkg::CIR_CTRL,
    cpx_pkg::CIR_OPND, cpx_pkg::CIR_IADDR}) else $error("bad write select");
  AST_RD_SEL: assert property (cir_rd |-> cir_sel != cpx_pkg::CIR_CTRL)
    else $error("control read");
  AST_IADDR_OUT: assert property (cir_wr && cir_sel == cpx_pkg::CIR_IADDR |->
    ##[1:8] (cir_wr && cir_sel == cpx_pkg::CIR_OPND)) else $error("no status write");
  AST_IADDR_IN: assert property (cir_rd && cir_sel == cpx_pkg::CIR_IADDR |->
    $past(cir_rd, 2) && $past(cir_sel, 2) == cpx_pkg::CIR_OPND) else $error("pointer first");
endmodule : cpx_link_sva

// [sim/tb.sv]
// bench joining both link ends
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // signals, rows and counters
  // ----------------------------------------
  typedef struct {logic [15:0] w, m; logic [1:0] md; logic [31:0] ea, an, a0; int nq;} cpx_row_s;
  logic        core_clk = 1'b0, rst = 1'b1, instr_start = 1'b0, prim_go = 1'b0;
  logic        cond_cat = 1'b0, complete = 1'b0, mem_ack = 1'b0, ea_ctrl = 1'b0;
  logic        ea_alter = 1'b0, ea_postinc = 1'b0, ea_predec = 1'b0;
  logic        busy, done, proto_viol, fline_exc, trace_exc, status_load, flush, fetch_super;
  logic        mem_req, mem_we, odd_len, ctrl_put, op_put, ia_put;
  logic [2:0]  mem_size, ea_ext_words = 3'h2;
  logic [7:0]  ev = 8'h0;
  logic [15:0] status_out, status_in = 16'h4000, resp_word = 16'h0, sel_mask = 16'h0;
  logic [31:0] scan_out, an_out, fetch_addr, mem_addr, op_out, ia_out, ctrl_out, a0 = 32'h0;
  logic [31:0] scan_in = 32'h1234, ea_addr = 32'h0, op_in = 32'h2000, ia_in = 32'h8000;
  logic [31:0] mem_rdata = 32'h0, mem_wdata;
  int          n_req = 0, cyc = 0, t_ia = 0, t_op = 0, n_fail = 0, total_checks = 0;
  // mode 0 control, 1 postincrement, 2 predecrement, 3 control not alterable
  cpx_row_s    rows [5] = '{'{16'h0104, 16'h0001, 2'h0, 32'h40, 32'h0, 32'h40, 1},
    '{16'h0106, 16'h8001, 2'h1, 32'h100, 32'h10C, 32'h100, 4},
    '{16'h210C, 16'h0003, 2'h2, 32'h200, 32'h1E8, 32'h1F4, 6},
    '{16'h0102, 16'h0000, 2'h0, 32'h80, 32'h0, 32'h0, 0},
    '{16'h2108, 16'hFFFF, 2'h0, 32'h300, 32'h0, 32'h300, 32}};
  cpx_cir_if cif ();
  cpx_main_end i_cpx_main_end (.core_clk, .rst, .cir(cif), .instr_start, .prim_go, .cond_cat,
    .status_in, .scan_in, .ea_ctrl, .ea_alter, .ea_postinc, .ea_predec, .ea_ext_words,
    .ea_addr, .mem_rdata, .mem_ack, .busy, .done, .come_again(), .proto_viol, .fline_exc,
    .unhandled(), .trace_exc, .status_out, .status_load, .scan_out, .an_out, .an_load(),
    .flush, .fetch_addr, .fetch_super, .mem_req, .mem_we, .mem_addr, .mem_size, .mem_wdata);
  cpx_copro_end i_cpx_copro_end (.core_clk, .rst, .cir(cif), .resp_word, .sel_mask, .op_in,
    .ia_in, .complete, .resp_take(), .op_take(), .op_out, .op_put, .ia_out, .ia_put,
    .ctrl_out, .ctrl_put, .odd_len);
  cpx_link_sva i_cpx_link_sva (.core_clk, .rst, .cir_sel(cif.cir_sel), .cir_rd(cif.cir_rd),
    .cir_wr(cif.cir_wr), .cir_wdata(cif.cir_wdata), .cir_rdata(cif.cir_rdata),
    .cp_complete(cif.cp_complete));
  initial forever #25 core_clk = ~core_clk;
  // memory acks a cycle later; events stay set until the next run clears them
  always @(posedge core_clk) begin
    mem_ack <= mem_req;
    mem_rdata <= mem_addr ^ 32'hA5A5_0000;
    cyc <= cyc + 1;
    if (mem_req && n_req == 0) a0 <= mem_addr;
    if (mem_req) n_req <= n_req + 1;
    if (ia_put) t_ia <= cyc;
    if (op_put) t_op <= cyc;
    ev <= ev | {odd_len, ctrl_put, fline_exc, proto_viol, done, trace_exc, flush, status_load};
  end
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("Error at %0t ns: %s", $time, msg);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // one primitive; the wait for idle is bounded
  task automatic run(input logic [15:0] w, m, input logic c, input logic [1:0] md,
                     input logic [31:0] ea);
    int i;
    @(negedge core_clk);
    ev = 8'h0;
    n_req = 0;
    a0 = 32'h0;
    t_ia = 0;
    t_op = 0;
    @(posedge core_clk);
    resp_word <= w;
    sel_mask <= m;
    cond_cat <= c;
    ea_addr <= ea;
    ea_ctrl <= md == 2'h0 || md == 2'h3;
    ea_alter <= md != 2'h3;
    ea_postinc <= md == 2'h1;
    ea_predec <= md == 2'h2;
    prim_go <= 1'b1;
    @(posedge core_clk);
    prim_go <= 1'b0;
    @(negedge core_clk);
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(negedge core_clk);
    if (i == 400) begin
      n_fail++;
      end_sim();
    end
    repeat (2) @(posedge core_clk);
    $display("run %h ended at %0t ns", w, $time);
  endtask : run
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[k]) begin
      run(rows[k].w, rows[k].m, 1'b0, rows[k].md, rows[k].ea);
      chk(ev[3] === 1'b1 && n_req == rows[k].nq && a0 === rows[k].a0, "moves");
      chk(scan_out === scan_in + 32'h4, "scan");
      if (rows[k].md != 2'h0) chk(an_out === rows[k].an, "an");
      if (rows[k].nq > 0) chk(mem_we === rows[k].w[13] &&
        (!mem_we || mem_wdata === op_in), "dir");
    end
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk(busy === 1'b0 && mem_size === cpx_pkg::SIZE_LONG, "reset");
    run(16'h0105, 16'h0001, 1'b0, 2'h0, 32'h0);
    chk(ev[7] === 1'b1 && ev[4] === 1'b1 && n_req == 0, "odd");
    run(16'h0104, 16'h0001, 1'b1, 2'h0, 32'h0);
    chk(ev[4] === 1'b1 && ev[3] !== 1'b1, "cond multi");
    run(16'h2201, 16'h0000, 1'b1, 2'h0, 32'h0);
    chk(ev[4] === 1'b1 && ev[0] !== 1'b1, "cond status");
    run(16'h0104, 16'h0001, 1'b0, 2'h2, 32'h0);
    chk(ev[5] === 1'b1 && ctrl_out === cpx_pkg::ABORT_MASK, "abort in");
    run(16'h2104, 16'h0001, 1'b0, 2'h3, 32'h0);
    chk(ev[5] === 1'b1 && ev[6] === 1'b1 && n_req == 0, "abort out");
    run(16'h0201, 16'h0000, 1'b0, 2'h0, 32'h0);
    chk(ia_out === scan_in && op_out[15:0] === status_in && t_ia < t_op, "ptr out");
    run(16'h0200, 16'h0000, 1'b0, 2'h0, 32'h0);
    chk(t_ia == 0 && t_op > 0 && op_out[15:0] === status_in, "sr out");
    // trace armed at start fires only on completion
    instr_start <= 1'b1;
    @(posedge core_clk);
    instr_start <= 1'b0;
    run(16'h2201, 16'h0000, 1'b0, 2'h0, 32'h0);
    chk(ev[1:0] === 2'h3 && status_out === op_in[15:0] && scan_out === ia_in, "in");
    chk(fetch_addr === ia_in && fetch_super === 1'b1 && ev[2] !== 1'b1, "refill");
    complete <= 1'b1;
    repeat (6) @(posedge core_clk);
    complete <= 1'b0;
    status_in <= 16'h0000;
    op_in <= 32'h6000;
    instr_start <= 1'b1;
    @(negedge core_clk);
    chk(ev[2] === 1'b1, "trace");
    @(posedge core_clk);
    instr_start <= 1'b0;
    run(16'h2200, 16'h0000, 1'b0, 2'h0, 32'h0);
    complete <= 1'b1;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    chk(ev[2] !== 1'b1 && status_out === 16'h6000, "late trace");
    end_sim();
  end
endmodule : tb
